//--- rtl/nvc_cfg.svh
// Timing counts and sequence codes for the nonvolatile SRAM host controller
`ifndef NVC_CFG_SVH
`define NVC_CFG_SVH
`define NVC_CLK_NS        25
`define NVC_STORE_NS      10000000
`define NVC_RECALL_NS     20000
`define NVC_RESTORE_NS    550000
`define NVC_STORE_CYC     ((`NVC_STORE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_RECALL_CYC    ((`NVC_RECALL_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_RESTORE_CYC   ((`NVC_RESTORE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_STROBE_CYC    2
`define NVC_SEQ0          14'h0E38
`define NVC_SEQ1          14'h31C7
`define NVC_SEQ2          14'h03E0
`define NVC_SEQ3          14'h3C1F
`define NVC_SEQ4          14'h303F
`define NVC_SEQ_STORE     14'h0FC0
`define NVC_SEQ_RECALL    14'h0C63
`endif

//--- rtl/nvc_pkg.sv
// Types for the nonvolatile SRAM host controller
package nvc_pkg;
    typedef enum logic [6:0] {
        NVC_POWERUP = 7'b000_0001,
        NVC_IDLE    = 7'b000_0010,
        NVC_SETUP   = 7'b000_0100,
        NVC_STROBE  = 7'b000_1000,
        NVC_HOLD    = 7'b001_0000,
        NVC_NEXT    = 7'b010_0000,
        NVC_BUSY    = 7'b100_0000
    } nvc_state_e;
    typedef enum logic [1:0] {
        NVC_OP_READ   = 2'b00,
        NVC_OP_WRITE  = 2'b01,
        NVC_OP_STORE  = 2'b10,
        NVC_OP_RECALL = 2'b11
    } nvc_op_e;
endpackage

//--- rtl/nvc_wait_timer.sv
// Down counter that times nonvolatile transfers
`timescale 1ns/10ps
module nvc_wait_timer #(
    parameter int WIDTH = 19
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] count_i,
    output logic                  done_o
);
    logic [WIDTH-1:0] count;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            count <= '0;
        else if (load_i)
            count <= count_i;
        else if (count != '0)
            count <= count - 1'b1;
    end
    assign done_o = (count == '0) && !load_i;
endmodule // nvc_wait_timer

//--- rtl/nvc_host.sv
// Host controller driving a 32K x 8 nonvolatile SRAM through its pins
// Overview of operation
// - Host holds address steady through the whole write strobe.
// - Host never holds a write active while power-up recall finishes.
// - Software transfer begins with five reads at fixed codes in order.
// - Each sequence read is its own chip-select strobe.
// - Sequence steps are reads; output enable level does not matter.
`timescale 1ns/10ps
`include "nvc_cfg.svh"
module nvc_host
    import nvc_pkg::*;
#(
    parameter int AW          = 15,
    parameter int DW          = 8,
    parameter int STORE_CYC   = `NVC_STORE_CYC,
    parameter int RECALL_CYC  = `NVC_RECALL_CYC,
    parameter int RESTORE_CYC = `NVC_RESTORE_CYC
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          req_valid_i,
    input  wire logic [1:0]    req_op_i,
    input  wire logic [AW-1:0] req_addr_i,
    input  wire logic [DW-1:0] req_wdata_i,
    output logic               req_ready_o,
    output logic               rsp_valid_o,
    output logic [DW-1:0]      rsp_rdata_o,
    output logic               busy_o,
    output logic [AW-1:0]      address_lines_o,
    output logic [DW-1:0]      data_lines_o,
    output logic               data_lines_oe_n_o,
    input  wire logic [DW-1:0] data_lines_i,
    output logic               chip_select_n_o,
    output logic               write_enable_n_o,
    output logic               output_enable_n_o,
    output logic               hw_store_n_o,
    output logic               hw_store_n_oe_n_o,
    input  wire logic          hw_store_n_i
);
    localparam int TW = 19;
    localparam logic [TW-1:0] STORE_LD   = TW'(STORE_CYC);
    localparam logic [TW-1:0] RECALL_LD  = TW'(RECALL_CYC);
    localparam logic [TW-1:0] RESTORE_LD = TW'(RESTORE_CYC);
    localparam logic [1:0]    STROBE_LD  = 2'(`NVC_STROBE_CYC);

    nvc_state_e state;
    nvc_op_e    op;
    logic [2:0] step;
    logic [1:0] scnt;
    logic       timer_load;
    logic [TW-1:0] timer_val;
    logic       timer_done;
    logic       powerup_load;

    nvc_wait_timer #(.WIDTH(TW)) u_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (timer_load),
        .count_i (timer_val),
        .done_o  (timer_done)
    );

    // Sequence step address; codes are 14 bits, top address bit left zero
    function automatic logic [AW-1:0] seq_addr(input logic [2:0] s, input nvc_op_e o);
        logic [13:0] c;
        c = `NVC_SEQ0;
        unique case (s)
            3'd0: c = `NVC_SEQ0;
            3'd1: c = `NVC_SEQ1;
            3'd2: c = `NVC_SEQ2;
            3'd3: c = `NVC_SEQ3;
            3'd4: c = `NVC_SEQ4;
            default: c = (o == NVC_OP_STORE) ? `NVC_SEQ_STORE : `NVC_SEQ_RECALL;
        endcase
        return AW'(c);
    endfunction

    logic is_seq;
    assign is_seq = (op == NVC_OP_STORE) || (op == NVC_OP_RECALL);

    assign timer_load = powerup_load
                      || (state == NVC_HOLD && is_seq && step == 3'd5);
    assign timer_val  = powerup_load ? RESTORE_LD
                      : (op == NVC_OP_STORE) ? STORE_LD : RECALL_LD;

    // Main sequencer
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state        <= NVC_POWERUP;
            op           <= NVC_OP_READ;
            step         <= 3'd0;
            scnt         <= 2'd0;
            powerup_load <= 1'b1;
        end
        else
        begin
            powerup_load <= 1'b0;
            unique case (state)
                NVC_POWERUP:
                    if (!powerup_load && timer_done)
                        state <= NVC_IDLE;
                NVC_IDLE:
                    if (req_valid_i)
                    begin
                        op    <= nvc_op_e'(req_op_i);
                        step  <= 3'd0;
                        state <= NVC_SETUP;
                    end
                NVC_SETUP:
                begin
                    scnt  <= STROBE_LD;
                    state <= NVC_STROBE;
                end
                NVC_STROBE:
                    if (scnt == 2'd1)
                        state <= NVC_HOLD;
                    else
                        scnt <= scnt - 2'd1;
                NVC_HOLD:
                    if (!is_seq)
                        state <= NVC_IDLE;
                    else if (step == 3'd5)
                        state <= NVC_BUSY;
                    else
                        state <= NVC_NEXT;
                NVC_NEXT:
                begin
                    // No other access is issued between steps, so no abort occurs
                    step  <= step + 3'd1;
                    state <= NVC_SETUP;
                end
                NVC_BUSY:
                    if (timer_done)
                    begin
                        step  <= 3'd0;
                        state <= NVC_IDLE;
                    end
                default:
                    state <= NVC_IDLE;
            endcase
        end
    end

    // Pin drive; address and data stay stable from setup through hold
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            address_lines_o   <= '0;
            data_lines_o      <= '0;
            data_lines_oe_n_o <= 1'b1;
            chip_select_n_o   <= 1'b1;
            write_enable_n_o  <= 1'b1;
            output_enable_n_o <= 1'b1;
        end
        else
        begin
            if (state == NVC_SETUP)
            begin
                address_lines_o <= is_seq ? seq_addr(step, op) : req_addr_i;
                data_lines_o    <= req_wdata_i;
                data_lines_oe_n_o <= (op != NVC_OP_WRITE);
            end
            else if (state == NVC_IDLE || state == NVC_BUSY)
                data_lines_oe_n_o <= 1'b1;
            // One chip-select pulse per access, even inside a sequence
            chip_select_n_o  <= !(state == NVC_SETUP || state == NVC_STROBE);
            write_enable_n_o <= !((state == NVC_SETUP || state == NVC_STROBE)
                                  && op == NVC_OP_WRITE);
            // Output enable stays high in writes to avoid bus contention
            output_enable_n_o <= !((state == NVC_SETUP || state == NVC_STROBE)
                                   && op != NVC_OP_WRITE);
        end
    end

    // Request port: host never lets a store pin request through
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            req_ready_o       <= 1'b0;
            rsp_valid_o       <= 1'b0;
            rsp_rdata_o       <= '0;
            busy_o            <= 1'b1;
            hw_store_n_o      <= 1'b1;
            hw_store_n_oe_n_o <= 1'b1;
        end
        else
        begin
            req_ready_o <= (state == NVC_IDLE) && !req_valid_i;
            busy_o      <= (state == NVC_POWERUP) || (state == NVC_BUSY)
                           || !hw_store_n_i;
            rsp_valid_o <= (state == NVC_HOLD) && !is_seq;
            if (state == NVC_STROBE && scnt == 2'd1 && op == NVC_OP_READ)
                rsp_rdata_o <= data_lines_i;
        end
    end

    // Address must not move while a write strobe is low
    addr_stable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!write_enable_n_o && $past(!write_enable_n_o)) |-> $stable(address_lines_o))
        else $error("address moved during write");
    oe_high_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !write_enable_n_o |-> output_enable_n_o)
        else $error("output enable low during write");
    cs_toggles_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(chip_select_n_o) |=> chip_select_n_o)
        else $error("select not released between accesses");
    seq_no_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (is_seq && state != NVC_IDLE) |-> write_enable_n_o)
        else $error("write inside sequence");
    busy_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == NVC_BUSY) |=> chip_select_n_o)
        else $error("access during transfer");
    pwr_no_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == NVC_POWERUP) |-> (write_enable_n_o && chip_select_n_o))
        else $error("write held during power-up recall");
    seq_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == NVC_SETUP && is_seq && step == 3'd0)
            |=> address_lines_o == AW'(`NVC_SEQ0))
        else $error("sequence did not start at first code");
    sixth_code_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == NVC_SETUP && op == NVC_OP_STORE && step == 3'd5)
            |=> address_lines_o == AW'(`NVC_SEQ_STORE))
        else $error("wrong store trigger code");
endmodule // nvc_host

//--- tb/nvc_sram_model.sv
// Behavioural nonvolatile SRAM answering the host controller's pins
`timescale 1ns/10ps
module nvc_sram_model #(
    parameter int RESTORE_NS = 300,
    parameter int STORE_NS   = 400,
    parameter int RECALL_NS  = 200
) (
    input  wire logic [14:0] addr_i,
    input  wire logic [7:0]  din_i,
    input  wire logic        cs_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    output logic [7:0]       dout_o,
    output logic             hsb_n_o,
    output int               viol_o
);
    logic [7:0]  mem [32768];
    logic [7:0]  nv [32768];
    logic [13:0] code [5] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
    int          step = 0;
    logic        xfer = 1'b1;
    logic        wr_on = 1'b0;
    // Time of the last write strobe edge; pins that move in that same step are not a fault
    realtime     wr_t = -1.0;
    initial
    begin
        hsb_n_o = 1'b1;
        viol_o = 0;
        for (int i = 0; i < 32768; i++)
            nv[i] = 8'h5a ^ i[7:0];
        #(RESTORE_NS) mem = nv;
        if (!cs_n_i && !we_n_i)
            viol_o++;
        xfer = 1'b0;
    end
    // Released lines show the inverse so a stale byte never passes for data
    assign dout_o = (!cs_n_i && !oe_n_i && we_n_i && !xfer) ? mem[addr_i]
                                                           : ~mem[addr_i];
    always @(cs_n_i or we_n_i)
    begin
        if (wr_on && (cs_n_i || we_n_i))
        begin
            mem[addr_i] = din_i;
            wr_on = 1'b0;
            wr_t = $realtime;
            step = 0;
        end
        if (!cs_n_i && !we_n_i && hsb_n_o && !xfer)
        begin
            wr_on = 1'b1;
            wr_t = $realtime;
            if (!oe_n_i)
                viol_o++;
        end
    end
    always @(addr_i)
        if (wr_on && $realtime != wr_t)
            viol_o++;
    // Steps count only at a rising select, so an address walk under one select is ignored
    always @(posedge cs_n_i)
        // A write ends with select and write enable rising together; never count it as a step
        if (we_n_i && !wr_on && $realtime != wr_t && !xfer)
        begin
            if (step == 5 && addr_i[13:0] inside {14'h0fc0, 14'h0c63})
            begin
                xfer = 1'b1;
                step = 0;
                if (addr_i[13:0] == 14'h0fc0)
                begin
                    hsb_n_o = 1'b0;
                    #(STORE_NS) nv = mem;
                    hsb_n_o = 1'b1;
                end
                else
                    #(RECALL_NS) mem = nv;
                xfer = 1'b0;
            end
            else if (step < 5 && addr_i[13:0] == code[step])
                step++;
            else
                step = (addr_i[13:0] == code[0]) ? 1 : 0;
        end
endmodule // nvc_sram_model

//--- tb/nvc_host_test.sv
// Self-checking testbench for the nonvolatile SRAM host controller
`timescale 1ns/10ps
module nvc_host_test
    import nvc_pkg::*;
    ;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic [1:0]  req_op_i = 2'h0;
    logic [14:0] req_addr_i = 15'h0000;
    logic [7:0]  req_wdata_i = 8'h00;
    logic        req_ready_o, rsp_valid_o, busy_o, data_lines_oe_n_o;
    logic [7:0]  rsp_rdata_o, data_lines_o, dev_dq;
    logic [14:0] address_lines_o;
    logic        chip_select_n_o, write_enable_n_o, output_enable_n_o;
    logic        hw_store_n_o, hw_store_n_oe_n_o, dev_hsb;
    int          viol, num_errors = 0, cmp_count = 0, cycles = 0;
    logic [31:0] seed = 32'h4c6e;
    logic [7:0]  ref_mem [32768];
    logic [7:0]  ref_nv [32768];
    logic [14:0] addrs [8];
    logic        busy_seen;
    // Pull-up on the busy pin; host enable is active low
    wire logic       hsb_w = dev_hsb & (hw_store_n_oe_n_o | hw_store_n_o);
    wire logic [7:0] dev_din = data_lines_oe_n_o ? ~data_lines_o : data_lines_o;

    always #12.5 clk_i = ~clk_i;

    nvc_host #(.STORE_CYC(20), .RECALL_CYC(10), .RESTORE_CYC(10)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
        .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .busy_o(busy_o), .address_lines_o(address_lines_o), .data_lines_o(data_lines_o),
        .data_lines_oe_n_o(data_lines_oe_n_o), .data_lines_i(dev_dq),
        .chip_select_n_o(chip_select_n_o), .write_enable_n_o(write_enable_n_o),
        .output_enable_n_o(output_enable_n_o), .hw_store_n_o(hw_store_n_o),
        .hw_store_n_oe_n_o(hw_store_n_oe_n_o), .hw_store_n_i(hsb_w));

    nvc_sram_model i_dev (
        .addr_i(address_lines_o), .din_i(dev_din), .cs_n_i(chip_select_n_o),
        .we_n_i(write_enable_n_o), .oe_n_i(output_enable_n_o), .dout_o(dev_dq),
        .hsb_n_o(dev_hsb), .viol_o(viol));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic access(input nvc_op_e op, input logic [14:0] a, input logic [7:0] d);
        int n;
        n = 0;
        do
            @(posedge clk_i);
        while (req_ready_o !== 1'b1 && ++n < 999);
        req_valid_i <= 1'b1;
        req_op_i <= op;
        req_addr_i <= a;
        req_wdata_i <= d;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        busy_seen = 1'b0;
        n = 0;
        // Transfers end when busy has been seen and the controller is ready again
        do
        begin
            @(posedge clk_i);
            busy_seen |= (busy_o === 1'b1);
        end
        while (++n < 99 && (op < NVC_OP_STORE ? rsp_valid_o !== 1'b1
                                              : !(busy_seen && req_ready_o === 1'b1)));
        chk_byte({7'h00, n < 99}, 8'h01);
        case (op)
            NVC_OP_WRITE: ref_mem[a] = d;
            NVC_OP_READ: chk_byte(rsp_rdata_o, ref_mem[a]);
            NVC_OP_STORE: ref_nv = ref_mem;
            default: ref_mem = ref_nv;
        endcase
        if (op >= NVC_OP_STORE)
            chk_byte({7'h00, busy_seen}, 8'h01);
        else
        begin
            @(posedge clk_i);
            chk_byte({7'h00, rsp_valid_o}, 8'h00);
        end
    endtask

    task automatic burst(input bit wr, input bit fresh);
        for (int i = 0; i < 8; i++)
        begin
            seed = xorshift(seed);
            if (fresh)
                addrs[i] = seed[14:0];
            access(wr ? NVC_OP_WRITE : NVC_OP_READ, addrs[i], seed[22:15]);
        end
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            num_errors++;
            $display("unexpected at %0t: run did not finish", $time);
            give_verdict();
        end
    end

    initial
    begin
        for (int i = 0; i < 32768; i++)
            ref_nv[i] = 8'h5a ^ i[7:0];
        ref_mem = ref_nv;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        access(NVC_OP_READ, 15'h0000, 8'h00);
        access(NVC_OP_READ, 15'h7fff, 8'h00);
        $display("test power-up recall ended");
        burst(1'b1, 1'b1);
        burst(1'b0, 1'b0);
        $display("test write and read ended");
        access(NVC_OP_STORE, 15'h0000, 8'h00);
        burst(1'b1, 1'b0);
        access(NVC_OP_RECALL, 15'h0000, 8'h00);
        burst(1'b0, 1'b0);
        $display("test store and recall ended");
        chk_byte({6'h00, hw_store_n_oe_n_o, hw_store_n_o}, 8'h03);
        chk_byte((viol == 0) ? 8'h01 : 8'h00, 8'h01);
        give_verdict();
    end
endmodule // nvc_host_test
